// ===== core/debounce_filter.sv
// Debouncing filter: the output follows the input only after it has held
// a new level for COUNT consecutive cycles. Input must already be synchronous.
`timescale 1ns/1ns
`default_nettype none
module debounce_filter #(
    parameter int COUNT = 200
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_level,
    output logic o_level
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    logic [CW-1:0] run;

    // Short glitches restart the count, so they never reach the output
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            run <= '0;
            o_level <= 1'b0;
        end else if (i_level == o_level) begin
            run <= '0;
        end else if (run == LAST) begin
            run <= '0;
            o_level <= i_level;
        end else begin
            run <= run + CW'(1);
        end
    end
endmodule
`default_nettype wire

// ===== core/level_sync.sv
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit changes slowly relative to the destination clock.
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= '0;
            o_sync <= '0;
        end else begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== core/pressure_temp_readout_diag.sv
// Readout and supervision core of a digital barometric pressure sensor.
// Assumes calibrated samples arrive on the reference clock, comparator and
// supply-monitor levels arrive asynchronously, the serial clock is a separate
// clock port, and the configuration memory answers one cycle after its address.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Results are 16-bit words
// - Results coded in two's complement
// - Under-range pressure gives negative code
// - Pressure code = 220 per kPa minus 8800
// - Over-span pressure saturates at 7fff
// - Temperature code = 150 per degree plus 7500
// - Negative temperature code means below -50 C
// - Sleep command from master enters sleep
// - No new results while asleep
// - Rising serial clock edge wakes device
// - Windowed bridge inputs ORed then debounced
// - Filtered bridge fault sets check-failure bit
// - Supply fault sets supply-failure bit
// - Both failure bits readable by master
// - Checksum over configuration memory at power-up
// - Checksum failure leaves results unwritten forever
// - Sleep entered only by command, no pin
module pressure_temp_readout_diag
    import readout_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_serial_clk,
    input wire logic [15:0] i_press_sample,
    input wire logic i_press_valid,
    input wire logic [15:0] i_temp_sample,
    input wire logic i_temp_valid,
    input wire logic i_sleep_cmd,
    input wire logic i_status_read,
    input wire bridge_cmp_s i_bridge_cmp,
    input wire logic i_bridge_supply_ok,
    input wire logic [7:0] i_cfg_data,
    output logic [CFG_ADDR_WIDTH-1:0] o_cfg_addr,
    output logic [RESULT_WIDTH-1:0] o_press_result,
    output logic [RESULT_WIDTH-1:0] o_temp_result,
    output logic o_press_updated,
    output logic o_temp_updated,
    output diag_status_s o_diag_status,
    output logic o_asleep,
    output logic o_cfg_ok,
    output logic o_cfg_fail
);

    op_mode_e mode;

    // Serial clock domain: a toggle flips on every rising edge, so each
    // edge becomes one event for the reference domain. A toggle is used
    // rather than a pulse because the serial clock may stop right after
    // the edge, leaving nothing to stretch a pulse across the crossing.
    logic wake_toggle;

    // Toggle on each rising serial clock edge
    always_ff @(posedge i_serial_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_toggle <= 1'b0;
        end else begin
            wake_toggle <= ~wake_toggle;
        end
    end

    // Cross the toggle and all asynchronous analog levels
    logic wake_toggle_sync;
    logic wake_toggle_seen;
    logic wake_event;
    bridge_cmp_s cmp_sync;
    logic supply_ok_sync;

    level_sync #(
        .WIDTH(6)
    ) u_level_sync (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async({wake_toggle, i_bridge_cmp, i_bridge_supply_ok}),
        .o_sync({wake_toggle_sync, cmp_sync, supply_ok_sync})
    );

    // The synchroniser resets to zero, which would read as a supply fault;
    // the supply check waits until both stages carry the real pin level
    logic [1:0] sync_fill;
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_fill <= 2'h0;
        end else begin
            sync_fill <= {sync_fill[0], 1'b1};
        end
    end

    // Edge of the synced toggle marks one serial clock rising edge
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_toggle_seen <= 1'b0;
        end else begin
            wake_toggle_seen <= wake_toggle_sync;
        end
    end

    // One event per serial edge; edges outside sleep are simply ignored
    assign wake_event = wake_toggle_sync ^ wake_toggle_seen;

    // Bridge diagnostics
    logic bridge_window_fault;
    logic bridge_fault_filtered;

    // Any input outside the quarter/three-quarter window is a fault
    assign bridge_window_fault = cmp_sync.pos_below_quarter
        | cmp_sync.pos_above_three_quarter
        | cmp_sync.neg_below_quarter
        | cmp_sync.neg_above_three_quarter;

    // Filter trades about 10 us of fault latency for immunity to chatter
    debounce_filter #(
        .COUNT(DEBOUNCE_CYCLES)
    ) u_bridge_filter (
        .i_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_level(bridge_window_fault),
        .o_level(bridge_fault_filtered)
    );

    // Sticky failure bits; a fault present during the read clear wins
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_diag_status <= '0;
        end else begin
            if (bridge_fault_filtered) begin
                o_diag_status.bridge_check_failure <= 1'b1;
            end else if (i_status_read) begin
                o_diag_status.bridge_check_failure <= 1'b0;
            end
            if (!supply_ok_sync && sync_fill[1]) begin
                o_diag_status.bridge_supply_failure <= 1'b1;
            end else if (i_status_read) begin
                o_diag_status.bridge_supply_failure <= 1'b0;
            end
        end
    end

    // Configuration memory checksum at power-up
    logic [7:0] crc;
    logic [7:0] data_idx;
    logic data_valid;
    logic check_done;
    logic check_pass;

    // Address walk: data bytes then the stored checksum byte
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_addr <= CFG_ADDR_RESET;
            data_idx <= CFG_ADDR_RESET;
            data_valid <= 1'b0;
        end else if (mode == MODE_CHECK) begin
            data_valid <= 1'b1;
            data_idx <= o_cfg_addr;
            if (o_cfg_addr != CFG_DATA_LEN) begin
                o_cfg_addr <= o_cfg_addr + 8'h01;
            end
        end else begin
            data_valid <= 1'b0;
        end
    end

    // Running CRC over the returned bytes
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            crc <= CFG_CRC_INIT;
        end else if (mode == MODE_CHECK && data_valid && data_idx != CFG_DATA_LEN) begin
            crc <= crc8_step(crc, i_cfg_data);
        end
    end

    // Last byte is compared, not folded in
    assign check_done = (mode == MODE_CHECK) && data_valid && (data_idx == CFG_DATA_LEN);
    assign check_pass = (crc == i_cfg_data);

    // Check outcome held for the host; never re-run without reset
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_ok <= 1'b0;
            o_cfg_fail <= 1'b0;
        end else if (check_done) begin
            o_cfg_ok <= check_pass;
            o_cfg_fail <= ~check_pass;
        end
    end

    // Operating mode
    // Idle on a bad checksum is terminal; only a power-up reset leaves it
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            mode <= MODE_CHECK;
        end else begin
            unique case (mode)
                MODE_CHECK: begin
                    if (check_done) begin
                        mode <= check_pass ? MODE_RUN : MODE_IDLE_FAIL;
                    end
                end
                MODE_RUN: begin
                    if (i_sleep_cmd) begin
                        mode <= MODE_SLEEP;
                    end
                end
                MODE_SLEEP: begin
                    if (wake_event) begin
                        mode <= MODE_RUN;
                    end
                end
                MODE_IDLE_FAIL: begin
                    mode <= MODE_IDLE_FAIL;
                end
            endcase
        end
    end

    // Sleep indication straight from a flop
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_asleep <= 1'b0;
        end else begin
            o_asleep <= (mode == MODE_RUN && i_sleep_cmd)
                || (mode == MODE_SLEEP && !wake_event);
        end
    end

    // Transfer functions
    // Products are sized so no bit of a full-scale sample is lost
    logic [23:0] press_prod;
    logic signed [17:0] press_wide;
    logic signed [24:0] temp_prod;
    logic signed [17:0] temp_wide;
    logic [15:0] next_press_result;
    logic [15:0] next_temp_result;

    // Pressure sample is unsigned kPa with 8 fraction bits
    assign press_prod = {8'h00, i_press_sample} * {16'h0000, PRESS_GAIN};
    assign press_wide = $signed({2'b00, press_prod[23:8]}) + PRESS_OFFSET;
    // Low end never clamps; above span codes saturate at the top value
    assign next_press_result = sat16(press_wide);

    // Temperature sample is signed degrees with 8 fraction bits
    assign temp_prod = $signed({{9{i_temp_sample[15]}}, i_temp_sample})
        * $signed({17'h00000, TEMP_GAIN});
    assign temp_wide = $signed({temp_prod[24], temp_prod[24:8]}) + TEMP_OFFSET;
    // Temperature map stays inside the word; the clamp is only a guard
    assign next_temp_result = sat16(temp_wide);

    // Result registers and update flags
    logic press_write;
    logic temp_write;

    // Only a verified, awake device acquires
    assign press_write = i_press_valid && (mode == MODE_RUN);
    assign temp_write = i_temp_valid && (mode == MODE_RUN);

    // Pressure result
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_press_result <= RESULT_RESET;
        end else if (press_write) begin
            o_press_result <= next_press_result;
        end
    end

    // Temperature result
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_temp_result <= RESULT_RESET;
        end else if (temp_write) begin
            o_temp_result <= next_temp_result;
        end
    end

    // Update flags: a write in the clearing cycle keeps the flag set
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_press_updated <= 1'b0;
            o_temp_updated <= 1'b0;
        end else begin
            if (press_write) begin
                o_press_updated <= 1'b1;
            end else if (i_status_read) begin
                o_press_updated <= 1'b0;
            end
            if (temp_write) begin
                o_temp_updated <= 1'b1;
            end else if (i_status_read) begin
                o_temp_updated <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ===== core/readout_pkg.sv
// Shared constants, types and helpers for the pressure/temperature readout block.
// Assumes a 20 MHz reference clock; the debounce cycle count below is derived from that rate.
package readout_pkg;

    // Reference clock and derived timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int DEBOUNCE_TIME_NS = 10000;
    localparam int DEBOUNCE_CYCLES = (DEBOUNCE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Result word format
    localparam int RESULT_WIDTH = 16;
    localparam int FRAC_BITS = 8;
    localparam logic [15:0] RESULT_POS_MAX = 16'h7fff;
    localparam logic [15:0] RESULT_NEG_MIN = 16'h8000;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // Linear transfer maps: code = gain * value + offset
    localparam logic [7:0] PRESS_GAIN = 8'hdc;
    localparam logic signed [17:0] PRESS_OFFSET = -18'sh0_2260;
    localparam logic [7:0] TEMP_GAIN = 8'h96;
    localparam logic signed [17:0] TEMP_OFFSET = 18'sh0_1d4c;

    // Configuration memory checksum
    localparam int CFG_ADDR_WIDTH = 8;
    localparam logic [7:0] CFG_DATA_LEN = 8'h3f;
    localparam logic [7:0] CFG_CRC_POLY = 8'hd5;
    localparam logic [7:0] CFG_CRC_INIT = 8'hff;
    localparam logic [7:0] CFG_ADDR_RESET = 8'h00;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_CHECK,
        MODE_RUN,
        MODE_SLEEP,
        MODE_IDLE_FAIL
    } op_mode_e;

    // Window comparator outputs for both bridge signal inputs
    typedef struct packed {
        logic pos_below_quarter;
        logic pos_above_three_quarter;
        logic neg_below_quarter;
        logic neg_above_three_quarter;
    } bridge_cmp_s;

    // Diagnostic status bits
    typedef struct packed {
        logic bridge_check_failure;
        logic bridge_supply_failure;
    } diag_status_s;

    // One CRC8 step over a byte, MSB first
    function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ CFG_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // Clamp an 18-bit signed value into the 16-bit two's-complement range
    function automatic logic [15:0] sat16(input logic signed [17:0] v);
        logic [15:0] r;
        r = v[15:0];
        if (v > 18'sh0_7fff) begin
            r = RESULT_POS_MAX;
        end else if (v < -18'sh0_8000) begin
            r = RESULT_NEG_MIN;
        end
        return r;
    endfunction

endpackage

// ===== verification/master_model.sv
// Far-side model: configuration memory and the master's serial clock.
// Assumes the core reads memory one ref cycle after showing the address.
`timescale 1ns/1ns
`default_nettype none
module master_model (
    input wire logic i_clk,
    input wire logic i_bad,
    input wire logic i_wake,
    input wire logic [7:0] i_addr,
    output logic [7:0] o_data,
    output logic o_scl
);
    logic [7:0] mem [0:63];
    logic [7:0] crc;
    // Fill memory and append the checksum; own CRC loop, not the core's
    initial begin
        crc = 8'hff;
        for (int k = 0; k < 63; k++) begin
            mem[k] = 8'(k * 7) ^ 8'h5a;
            crc = crc ^ mem[k];
            for (int b = 0; b < 8; b++) begin
                crc = crc[7] ? ({crc[6:0], 1'b0} ^ 8'hd5) : {crc[6:0], 1'b0};
            end
        end
        mem[63] = crc;
        o_scl = 1'b1;
    end
    // Registered read: data follows the address by one cycle.
    // Bad memory is modelled by an inverted checksum byte.
    always @(posedge i_clk) begin
        o_data <= (i_addr == 8'h3f && i_bad) ? ~mem[63] : mem[i_addr[5:0]];
    end
    // Clock idles high between bursts; a wake request gives four pulses
    always @(posedge i_wake) begin
        repeat (4) begin
            #40 o_scl = 1'b0;
            #40 o_scl = 1'b1;
        end
    end
endmodule
`default_nettype wire

// ===== verification/readout_asserts.sv
// Checker for the readout core: result maps, flags, sleep and diagnostics.
// Sees only the top ports; bound to every instance of the core below.
`timescale 1ns/1ns
`default_nettype none
module readout_asserts
    import readout_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [15:0] i_press_sample,
    input wire logic i_press_valid,
    input wire logic [15:0] i_temp_sample,
    input wire logic i_temp_valid,
    input wire logic i_sleep_cmd,
    input wire bridge_cmp_s i_bridge_cmp,
    input wire logic i_bridge_supply_ok,
    input wire logic [15:0] o_press_result,
    input wire logic [15:0] o_temp_result,
    input wire logic o_press_updated,
    input wire logic o_temp_updated,
    input wire diag_status_s o_diag_status,
    input wire logic o_asleep,
    input wire logic o_cfg_ok,
    input wire logic o_cfg_fail
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    logic signed [31:0] p_raw;
    logic signed [31:0] t_raw;
    logic [15:0] p_exp;
    logic run;
    logic any_cmp;
    // Expected codes; only the pressure map can leave the word upwards
    always_comb begin
        p_raw = (($signed({16'h0, i_press_sample}) * 220) >>> 8) - 8800;
        t_raw = (($signed(i_temp_sample) * 150) >>> 8) + 7500;
        p_exp = (p_raw > 32767) ? 16'h7fff : p_raw[15:0];
        run = o_cfg_ok && !o_asleep && !i_sleep_cmd;
        any_cmp = |i_bridge_cmp;
    end
    sleep_by_cmd_a: assert property ($rose(o_asleep) |-> $past(i_sleep_cmd))
        else $error("sleep entered without a command");
    press_map_a: assert property (run && i_press_valid |=> o_press_result == $past(p_exp))
        else $error("pressure code off the linear map");
    temp_map_a: assert property (run && i_temp_valid |=> o_temp_result == $past(t_raw[15:0]))
        else $error("temperature code off the linear map");
    asleep_hold_a: assert property (o_asleep && i_press_valid |=> $stable(o_press_result))
        else $error("pressure written while asleep");
    press_flag_a: assert property (run && i_press_valid |=> o_press_updated)
        else $error("update flag not set on write");
    fail_idle_a: assert property (o_cfg_fail |-> !o_press_updated && !o_temp_updated)
        else $error("result flag set after checksum failure");
    cfg_sticky_a: assert property (o_cfg_ok || o_cfg_fail |=> $stable({o_cfg_ok, o_cfg_fail}))
        else $error("checksum outcome changed");
    supply_flag_a: assert property (!i_bridge_supply_ok |-> ##[1:4] o_diag_status.bridge_supply_failure)
        else $error("supply fault not flagged in time");
    bridge_debounce_a: assert property ($rose(o_diag_status.bridge_check_failure) |-> $past(any_cmp, 190))
        else $error("bridge fault flagged before debounce");
endmodule
bind pressure_temp_readout_diag readout_asserts chk (.i_ref_clk, .i_rst, .i_press_sample,
    .i_press_valid, .i_temp_sample, .i_temp_valid, .i_sleep_cmd, .i_bridge_cmp,
    .i_bridge_supply_ok, .o_press_result, .o_temp_result, .o_press_updated,
    .o_temp_updated, .o_diag_status, .o_asleep, .o_cfg_ok, .o_cfg_fail);
`default_nettype wire

// ===== verification/tb.sv
// Testbench for the readout core: maps, sleep/wake, diagnostics, checksum.
// Inputs change on the rising ref clock; the master model feeds memory and SCL.
`timescale 1ns/1ns
`default_nettype none
module tb
    import readout_pkg::*;
;
    logic clk, rst, scl, pv, tv, slp, srd, sok, bad, wake, pu, tu, asl, cok, cfl;
    logic [15:0] ps, ts, pr, tr;
    logic [7:0] addr, data;
    bridge_cmp_s cmp;
    diag_status_s dg;
    int error_cnt, cmp_count, n;
    logic [15:0] pin [5] = '{16'h2800, 16'hb400, 16'hffff, 16'h1400, 16'h0000};
    logic [15:0] pout [5] = '{16'h0000, 16'h7850, 16'h7fff, 16'heed0, 16'hdda0};
    logic [15:0] tin [5] = '{16'h0000, 16'hce00, 16'h7d00, 16'hc400, 16'h7fff};
    logic [15:0] tout [5] = '{16'h1d4c, 16'h0000, 16'h668a, 16'hfa24, 16'h684b};
    pressure_temp_readout_diag uut (.i_ref_clk(clk), .i_rst(rst), .i_serial_clk(scl),
        .i_press_sample(ps), .i_press_valid(pv), .i_temp_sample(ts), .i_temp_valid(tv),
        .i_sleep_cmd(slp), .i_status_read(srd), .i_bridge_cmp(cmp),
        .i_bridge_supply_ok(sok), .i_cfg_data(data), .o_cfg_addr(addr),
        .o_press_result(pr), .o_temp_result(tr), .o_press_updated(pu),
        .o_temp_updated(tu), .o_diag_status(dg), .o_asleep(asl), .o_cfg_ok(cok),
        .o_cfg_fail(cfl));
    master_model pm (.i_clk(clk), .i_bad(bad), .i_wake(wake), .i_addr(addr),
        .o_data(data), .o_scl(scl));
    // 20 MHz reference clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Reset for three cycles, then let the checksum walk finish
    task automatic start(input logic b);
        @(posedge clk);
        rst <= 1'b1;
        bad <= b;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        tick(70);
    endtask
    task automatic send(input logic [15:0] p, input logic [15:0] t);
        @(posedge clk);
        pv <= 1'b1;
        tv <= 1'b1;
        ps <= p;
        ts <= t;
        @(posedge clk);
        pv <= 1'b0;
        tv <= 1'b0;
        #1;
    endtask
    // One-cycle command pulse: sleep or status read
    task automatic strobe(input logic to_sleep);
        @(posedge clk);
        slp <= to_sleep;
        srd <= !to_sleep;
        @(posedge clk);
        slp <= 1'b0;
        srd <= 1'b0;
        #1;
    endtask
    task automatic wrap_up;
        $display("error_cnt=%0d cmp_count=%0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run of about 2000 cycles
    initial begin
        #1000000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        {pv, tv, slp, srd, wake, bad} = '0;
        rst = 1'b1;
        sok = 1'b1;
        cmp = '0;
        ps = '0;
        ts = '0;
        error_cnt = 0;
        cmp_count = 0;
        start(1'b0);
        chk("cfg_ok", 16'h1, 16'(cok));
        chk("cfg_addr", 16'h003f, 16'(addr));
        chk("diag_status", 16'h0, 16'(dg));
        for (int i = 0; i < 5; i++) begin
            send(pin[i], tin[i]);
            chk("press_result", pout[i], pr);
            chk("temp_result", tout[i], tr);
            chk("press_updated", 16'h1, 16'(pu));
            chk("temp_updated", 16'h1, 16'(tu));
        end
        strobe(1'b0);
        chk("temp_updated", 16'h0, 16'(tu));
        strobe(1'b1);
        chk("asleep", 16'h1, 16'(asl));
        send(16'h2800, 16'h0000);
        chk("press_result", 16'hdda0, pr);
        chk("press_updated", 16'h0, 16'(pu));
        @(posedge clk);
        wake <= 1'b1;
        n = 0;
        while (asl !== 1'b0 && n < 20) begin
            tick(1);
            n++;
        end
        wake <= 1'b0;
        chk("asleep", 16'h0, 16'(asl));
        send(16'h2800, 16'h0000);
        chk("press_result", 16'h0000, pr);
        // Each comparator alone must raise the bridge fault after debounce
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cmp <= bridge_cmp_s'(4'(1 << i));
            tick(150);
            chk("bridge_check", 16'h0, 16'(dg.bridge_check_failure));
            tick(70);
            chk("bridge_check", 16'h1, 16'(dg.bridge_check_failure));
            @(posedge clk);
            cmp <= '0;
            tick(220);
            strobe(1'b0);
            chk("bridge_check", 16'h0, 16'(dg.bridge_check_failure));
        end
        @(posedge clk);
        sok <= 1'b0;
        tick(5);
        chk("bridge_supply", 16'h1, 16'(dg.bridge_supply_failure));
        @(posedge clk);
        sok <= 1'b1;
        tick(4);
        strobe(1'b0);
        chk("bridge_supply", 16'h0, 16'(dg.bridge_supply_failure));
        start(1'b1);
        chk("cfg_fail", 16'h1, 16'(cfl));
        send(16'hb400, 16'h0000);
        chk("press_updated", 16'h0, 16'(pu));
        chk("press_result", 16'h0000, pr);
        chk("temp_updated", 16'h0, 16'(tu));
        wrap_up();
    end
endmodule
`default_nettype wire
